//--- hw/adcsp_consts.vh
`ifndef ADCSP_CONSTS_VH
`define ADCSP_CONSTS_VH

`define ADCSP_RES_W        16
`define ADCSP_FIFO_DEPTH   16
`define ADCSP_FIFO_AW      4
`define ADCSP_BITS_ALL     5'h10
`define ADCSP_CFG_EDGES    4'h9
`define ADCSP_CFG_RESET    9'h000
`define ADCSP_CFG_BIPOLAR  7
`define ADCSP_CFG_WIDE     6
`define ADCSP_CFG_PD       5
`define ADCSP_CFG_SCALED   4
`define ADCSP_CFG_FAST     3
`define ADCSP_CFG_CODING   2
`define ADCSP_RANGE_5V     2'h0
`define ADCSP_RANGE_10V    2'h1
`define ADCSP_RANGE_PM5V   2'h2
`define ADCSP_MODE_STD     2'h0
`define ADCSP_MODE_SCALED  2'h1
`define ADCSP_MODE_FAST    2'h2

`endif

//--- hw/adcsp_top.v
`include "adcsp_consts.vh"
`default_nettype none

module adcsp_fifo #(
    parameter WIDTH = `ADCSP_RES_W,
    parameter DEPTH = `ADCSP_FIFO_DEPTH,
    parameter AW    = `ADCSP_FIFO_AW
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             rst,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg  [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr_r;
    reg  [AW-1:0]    rd_ptr_r;
    reg  [AW:0]      count_r;
    wire             push;
    wire             pop;

    assign in_ready  = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data  = mem_r[rd_ptr_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk_sys) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
            end
            if (push & ~pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop & ~push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

// Contract
// - After busy falls, result is readable while chip select and read strobe are low.
// - Result shifts out MSB first over exactly sixteen host clock pulses.
// - Daisy input bits are passed through to the serial result output.
// - Daisy input sampled on the edge opposite the shifting edge.
// - Upstream MSB appears in the cycle after the local LSB.
// - During conversion, the previous result is read with both strobes low.
// - Conversion ending with a partial read pulses the read incomplete flag.
// - A read may span the end of one and start of the next conversion.
// - Pin settings accepted any time in parallel or pin configured serial mode.
// - Configuration port works only in serial mode with port configuration.
// - Nine bit shift register, MSB first; ninth edge applies new settings.
// - Reserved bits 1 and 0 are never written by the port.
// - Reset clears the whole configuration word to zero.
// - Bits 7 and 6 select the input range.
// - Bits 4 and 3 select standard, power scaled or fastest mode.
// - Bit 5 powers down the converter; the port stays writable.
module adcsp_top #(
    parameter RES_W      = `ADCSP_RES_W,
    parameter FIFO_DEPTH = `ADCSP_FIFO_DEPTH,
    parameter FIFO_AW    = `ADCSP_FIFO_AW
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             rst,
    // Converter core
    input  wire             conv_busy,
    input  wire [RES_W-1:0] conv_result,
    input  wire             conv_result_valid,
    output wire             conv_result_ready,
    // Serial read pins
    input  wire             chip_select_n,
    input  wire             read_n,
    input  wire             result_shift_clock,
    input  wire             daisy_serial_in,
    input  wire             clock_polarity_invert,
    output reg              serial_result_out,
    output reg              serial_result_oe_n,
    output reg              read_incomplete_flag,
    // Interface mode pins
    input  wire             serial_parallel_select,
    input  wire             pin_or_port_config_select,
    // Configuration pins
    input  wire             pin_range_bipolar,
    input  wire             pin_wide_range_bit,
    input  wire             pin_power_down_bit,
    input  wire             pin_mode_scaled,
    input  wire             pin_mode_fast,
    input  wire             pin_output_coding_select,
    // Configuration port
    input  wire             cfg_port_select_n,
    input  wire             cfg_serial_clock,
    input  wire             cfg_serial_in,
    // Applied configuration
    output reg  [1:0]       range_sel,
    output reg  [1:0]       mode_sel,
    output reg              power_down,
    output reg              output_coding_select
);
    localparam NSYNC = 16;
    localparam I_CS   = 0;
    localparam I_RD   = 1;
    localparam I_SCK  = 2;
    localparam I_DIN  = 3;
    localparam I_INV  = 4;
    localparam I_SER  = 5;
    localparam I_HW   = 6;
    localparam I_BIP  = 7;
    localparam I_WIDE = 8;
    localparam I_PD   = 9;
    localparam I_SCL  = 10;
    localparam I_FAST = 11;
    localparam I_COD  = 12;
    localparam I_CCS  = 13;
    localparam I_CCK  = 14;
    localparam I_CIN  = 15;

    wire [NSYNC-1:0] raw_in;
    reg  [NSYNC-1:0] sync1_r;
    reg  [NSYNC-1:0] sync2_r;
    reg  [NSYNC-1:0] sync3_r;

    assign raw_in = {cfg_serial_in, cfg_serial_clock, cfg_port_select_n,
                     pin_output_coding_select, pin_mode_fast, pin_mode_scaled,
                     pin_power_down_bit, pin_wide_range_bit, pin_range_bipolar,
                     pin_or_port_config_select, serial_parallel_select,
                     clock_polarity_invert, daisy_serial_in, result_shift_clock,
                     read_n, chip_select_n};

    // Two stage synchronisers, third stage only for edge finding
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1_r <= {NSYNC{1'b0}};
            sync2_r <= {NSYNC{1'b0}};
            sync3_r <= {NSYNC{1'b0}};
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    wire inv      = sync2_r[I_INV];
    wire ser_mode = sync2_r[I_SER];
    wire sck_rise = sync2_r[I_SCK] & ~sync3_r[I_SCK];
    wire sck_fall = ~sync2_r[I_SCK] & sync3_r[I_SCK];
    wire cck_rise = sync2_r[I_CCK] & ~sync3_r[I_CCK];
    wire cck_fall = ~sync2_r[I_CCK] & sync3_r[I_CCK];
    wire shift_edge  = inv ? sck_fall : sck_rise;
    wire sample_edge = inv ? sck_rise : sck_fall;
    wire cfg_edge    = inv ? cck_fall : cck_rise;
    wire selected    = ~sync2_r[I_CS] & ~sync2_r[I_RD] & ser_mode;

    // Result buffer between the converter core and the shifter
    wire             fifo_valid;
    wire             fifo_pop;
    wire [RES_W-1:0] fifo_data;

    adcsp_fifo #(
        .WIDTH (RES_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (conv_result_valid),
        .in_ready  (conv_result_ready),
        .in_data   (conv_result),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    reg  [RES_W-1:0] shift_r;
    reg  [4:0]       bit_cnt_r;
    reg              daisy_r;
    reg              busy_prev_r;
    // Set once the shifter has taken a word; before that any word loads
    reg              held_r;
    wire             read_idle;
    wire             read_part;
    wire [RES_W-1:0] coded;

    assign read_idle = (bit_cnt_r == 5'h00);
    assign read_part = ~read_idle & (bit_cnt_r != `ADCSP_BITS_ALL);
    // Load a fresh result only when no read of the held one is pending:
    // an empty shifter, or a fully read word once the host has let go.
    // A word with zero or some bits shifted is kept until it is finished.
    assign fifo_pop  = fifo_valid & (~held_r | (~read_idle & ~read_part & ~selected));
    assign coded     = {conv_msb(fifo_data[RES_W-1]), fifo_data[RES_W-2:0]};

    function conv_msb;
        input msb;
        begin
            conv_msb = msb ^ output_coding_select;
        end
    endfunction

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            shift_r   <= {RES_W{1'b0}};
            bit_cnt_r <= 5'h00;
            daisy_r   <= 1'b0;
            held_r    <= 1'b0;
        end else begin
            if (selected & sample_edge) begin
                daisy_r <= sync2_r[I_DIN];
            end
            if (fifo_pop) begin
                shift_r   <= coded;
                bit_cnt_r <= 5'h00;
                held_r    <= 1'b1;
            end else if (selected & shift_edge) begin
                // From the sixteenth shift on, the output follows the daisy
                // bit taken at the preceding sample edge, so the upstream
                // word directly follows the local LSB.
                if (bit_cnt_r >= (`ADCSP_BITS_ALL - 5'h01)) begin
                    shift_r[RES_W-1] <= daisy_r;
                end else begin
                    shift_r <= {shift_r[RES_W-2:0], daisy_r};
                end
                if (bit_cnt_r != `ADCSP_BITS_ALL) begin
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                end
            end
        end
    end

    // Pin drivers and read incomplete pulse
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            serial_result_out    <= 1'b0;
            serial_result_oe_n   <= 1'b1;
            read_incomplete_flag <= 1'b0;
            busy_prev_r          <= 1'b0;
        end else begin
            serial_result_out    <= shift_r[RES_W-1];
            serial_result_oe_n   <= ~selected;
            busy_prev_r          <= conv_busy;
            read_incomplete_flag <= busy_prev_r & ~conv_busy & read_part;
        end
    end

    // Serial configuration port
    reg  [8:0] cfg_shift_r;
    reg  [3:0] cfg_cnt_r;
    reg  [8:0] cfg_word_r;
    wire       sw_mode = ser_mode & ~sync2_r[I_HW];

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_shift_r <= 9'h000;
            cfg_cnt_r   <= 4'h0;
            cfg_word_r  <= `ADCSP_CFG_RESET;
        end else if (sync2_r[I_CCS]) begin
            cfg_cnt_r <= 4'h0;
        end else if (cfg_edge & (cfg_cnt_r != `ADCSP_CFG_EDGES)) begin
            cfg_shift_r <= {cfg_shift_r[7:0], sync2_r[I_CIN]};
            cfg_cnt_r   <= cfg_cnt_r + 4'h1;
            if ((cfg_cnt_r == `ADCSP_CFG_EDGES - 4'h1) & sw_mode) begin
                cfg_word_r[8:2] <= cfg_shift_r[7:1];
            end
        end
    end

    // Applied settings from pins or from the port
    wire hw_src   = ~ser_mode | sync2_r[I_HW];
    wire bip_e    = hw_src ? sync2_r[I_BIP]  : cfg_word_r[`ADCSP_CFG_BIPOLAR];
    wire wide_e   = hw_src ? sync2_r[I_WIDE] : cfg_word_r[`ADCSP_CFG_WIDE];
    wire pd_e     = hw_src ? sync2_r[I_PD]   : cfg_word_r[`ADCSP_CFG_PD];
    wire scaled_e = hw_src ? sync2_r[I_SCL]  : cfg_word_r[`ADCSP_CFG_SCALED];
    wire fast_e   = hw_src ? sync2_r[I_FAST] : cfg_word_r[`ADCSP_CFG_FAST];
    wire coding_e = hw_src ? sync2_r[I_COD]  : cfg_word_r[`ADCSP_CFG_CODING];

    reg [1:0] range_nxt;
    reg [1:0] mode_nxt;

    always @* begin
        case ({bip_e, wide_e})
            2'h0:    range_nxt = `ADCSP_RANGE_5V;
            2'h2:    range_nxt = `ADCSP_RANGE_PM5V;
            default: range_nxt = `ADCSP_RANGE_10V;
        endcase
        case ({fast_e, scaled_e})
            2'h1:    mode_nxt = `ADCSP_MODE_SCALED;
            2'h2:    mode_nxt = `ADCSP_MODE_FAST;
            default: mode_nxt = `ADCSP_MODE_STD;
        endcase
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            range_sel            <= `ADCSP_RANGE_5V;
            mode_sel             <= `ADCSP_MODE_STD;
            power_down           <= 1'b0;
            output_coding_select <= 1'b0;
        end else begin
            range_sel            <= range_nxt;
            mode_sel             <= mode_nxt;
            power_down           <= pd_e;
            output_coding_select <= coding_e;
        end
    end
endmodule

`default_nettype wire

//--- verif/adcsp_chk.sv
`default_nettype none
module adcsp_chk (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // Core and read link
    input wire logic       conv_busy,
    input wire logic       conv_result_valid,
    input wire logic       chip_select_n,
    input wire logic       read_n,
    input wire logic       result_shift_clock,
    input wire logic       serial_result_out,
    input wire logic       serial_result_oe_n,
    input wire logic       read_incomplete_flag,
    // Configuration
    input wire logic       serial_parallel_select,
    input wire logic       pin_or_port_config_select,
    input wire logic       pin_power_down_bit,
    input wire logic       cfg_port_select_n,
    input wire logic [1:0] range_sel,
    input wire logic [1:0] mode_sel,
    input wire logic       power_down,
    input wire logic       output_coding_select
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_rst; $fell(rst) |-> serial_result_oe_n && range_sel == 2'h0 && mode_sel == 2'h0 && !power_down && !output_coding_select; endproperty
    a_rst: assert property (p_rst) else $error("not clear after reset");
    property p_oe_off; chip_select_n [*6] |-> serial_result_oe_n; endproperty
    a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
    property p_oe_on; (!chip_select_n && !read_n && serial_parallel_select) [*6] |-> !serial_result_oe_n; endproperty
    a_oe_on: assert property (p_oe_on) else $error("output not driven while selected");
    property p_pulse; read_incomplete_flag |=> !read_incomplete_flag; endproperty
    a_pulse: assert property (p_pulse) else $error("flag longer than one cycle");
    property p_cause; read_incomplete_flag |-> !conv_busy && ($past(conv_busy) || $past(conv_busy, 2)); endproperty
    a_cause: assert property (p_cause) else $error("flag without end of conversion");
    property p_hold; (cfg_port_select_n && !pin_or_port_config_select && serial_parallel_select) [*8] |=> $stable({range_sel, mode_sel, power_down, output_coding_select}); endproperty
    a_hold: assert property (p_hold) else $error("config changed while port idle");
    property p_bit; (!serial_result_oe_n && !conv_result_valid && $stable(result_shift_clock)) [*7] |=> $stable(serial_result_out); endproperty
    a_bit: assert property (p_bit) else $error("data bit moved without clock");
    property p_pd; (!serial_parallel_select && pin_power_down_bit) [*6] |-> power_down; endproperty
    a_pd: assert property (p_pd) else $error("power down pin ignored");
endmodule
bind adcsp_top adcsp_chk i_adcsp_chk (.*);
`default_nettype wire

//--- verif/adcsp_host.sv
`default_nettype none
module adcsp_host (
    // Read link
    output logic      chip_select_n,
    output logic      read_n,
    output logic      result_shift_clock,
    output logic      daisy_serial_in,
    input  wire logic serial_result_out,
    // Configuration port
    output logic      cfg_port_select_n,
    output logic      cfg_serial_clock,
    output logic      cfg_serial_in
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HP = 32;
    initial begin
        {chip_select_n, read_n, cfg_port_select_n} = 3'h7;
        {result_shift_clock, daisy_serial_in, cfg_serial_clock, cfg_serial_in} = 4'h0;
    end
    // Clock idles low; from the fifteenth clock on, the upstream word enters on the daisy input
    task automatic rd(input int n, input logic [15:0] up, output logic [31:0] got);
        got = 32'h0;
        {chip_select_n, read_n} = 2'h0;
        #48;
        for (int i = 0; i < n; i++) begin
            got = {got[30:0], serial_result_out};
            result_shift_clock = 1'h1;
            #HP;
            daisy_serial_in = (i >= 14 && i < 30) ? up[29 - i] : ~daisy_serial_in;
            result_shift_clock = 1'h0;
            #HP;
        end
        {chip_select_n, read_n} = 2'h3;
        daisy_serial_in = 1'h0;
        #HP;
    endtask
    // Nine bits MSB first on rising clock edges; sel low leaves the port deselected
    task automatic cw(input logic [8:0] w, input logic sel);
        cfg_port_select_n = ~sel;
        #HP;
        for (int i = 8; i >= 0; i--) begin
            cfg_serial_in = w[i];
            #HP;
            cfg_serial_clock = 1'h1;
            #HP;
            cfg_serial_clock = 1'h0;
        end
        #HP;
        cfg_port_select_n = 1'h1;
        cfg_serial_in = ~cfg_serial_in;
        #HP;
    endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
`include "adcsp_consts.vh"
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("Error %s exp %h got %h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'h0, rst = 1'h1, conv_busy = 1'h0, conv_result_valid = 1'h0;
    logic clock_polarity_invert = 1'h0, serial_parallel_select = 1'h1, ok;
    logic pin_or_port_config_select = 1'h0, pin_range_bipolar = 1'h0, pin_wide_range_bit = 1'h0;
    logic pin_power_down_bit = 1'h0, pin_mode_scaled = 1'h0, pin_mode_fast = 1'h0;
    logic pin_output_coding_select = 1'h0;
    logic [15:0] conv_result = 16'h0, w, u;
    logic [15:0] q[$];
    logic [31:0] got;
    logic [5:0] v;
    wire conv_result_ready, chip_select_n, read_n, result_shift_clock, daisy_serial_in;
    wire cfg_port_select_n, cfg_serial_clock, cfg_serial_in, serial_result_out;
    wire serial_result_oe_n, read_incomplete_flag, power_down, output_coding_select;
    wire [1:0] range_sel, mode_sel;
    int fail_count = 0, compares = 0, flags = 0, seed = 25;
    adcsp_top i_adcsp_top (.*);
    adcsp_host i_adcsp_host (.*);
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (read_incomplete_flag === 1'h1) flags++;
    function automatic logic [1:0] f_rng(input logic b, input logic t);
        return {b & ~t, t};
    endfunction
    function automatic logic [1:0] f_mode(input logic s, input logic f);
        return {f & ~s, s & ~f};
    endfunction
    // v holds bipolar, wide, power down, scaled, fast, coding
    task automatic chk_cfg(input logic [5:0] e);
        `CHK("range", f_rng(e[5], e[4]), range_sel)
        `CHK("mode", f_mode(e[2], e[1]), mode_sel)
        `CHK("pd", e[3], power_down)
        `CHK("coding", e[0], output_coding_select)
    endtask
    task automatic push(input logic [15:0] d, output logic a);
        conv_result = d;
        conv_result_valid = 1'h1;
        #1 a = conv_result_ready;
        @(negedge clk_sys);
    endtask
    task automatic conclude;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        fail_count++;
        conclude;
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'h0;
        repeat (4) @(negedge clk_sys);
        `CHK("oe idle", 1'h1, serial_result_oe_n)
        chk_cfg(6'h00);
        // Fill until refused, then drain with the first read chained
        do begin
            w = $random(seed);
            push(w, ok);
            if (ok) q.push_back(w);
        end while (ok && q.size() < 20);
        conv_result_valid = 1'h0;
        `CHK("accepted", `ADCSP_FIFO_DEPTH + 1, q.size())
        u = $random(seed);
        w = q.pop_front();
        i_adcsp_host.rd(32, u, got);
        `CHK("chain", {w, u}, got)
        while (q.size() > 0) begin
            repeat (6) @(negedge clk_sys);
            w = q.pop_front();
            i_adcsp_host.rd(16, 16'h0, got);
            `CHK("word", w, got[15:0])
        end
        // Partial read cut by a conversion end, finished during the next one
        w = $random(seed);
        u = $random(seed);
        push(w, ok);
        push(u, ok);
        conv_result_valid = 1'h0;
        repeat (4) @(negedge clk_sys);
        i_adcsp_host.rd(5, 16'h0, got);
        `CHK("head", w[15:11], got[4:0])
        conv_busy = 1'h1;
        repeat (10) @(negedge clk_sys);
        conv_busy = 1'h0;
        repeat (4) @(negedge clk_sys);
        `CHK("flag", 1, flags)
        conv_busy = 1'h1;
        i_adcsp_host.rd(11, 16'h0, got);
        `CHK("tail", w[10:0], got[10:0])
        conv_busy = 1'h0;
        repeat (4) @(negedge clk_sys);
        `CHK("no flag", 1, flags)
        i_adcsp_host.rd(16, 16'h0, got);
        `CHK("next", u, got[15:0])
        // Port writes over every range and mode code, then one while deselected
        for (int i = 0; i < 8; i++) begin
            w = $random(seed);
            v = {i[1], i[0], w[0], i[0], i[1], w[1]};
            i_adcsp_host.cw({1'h1, v, w[3:2]}, 1'h1);
            chk_cfg(v);
        end
        i_adcsp_host.cw(9'h1fc, 1'h0);
        chk_cfg(v);
        // Pin configuration in parallel mode, last pass in serial pin mode
        pin_or_port_config_select = 1'h1;
        for (int i = 0; i < 9; i++) begin
            w = $random(seed);
            serial_parallel_select = (i == 8);
            {pin_range_bipolar, pin_wide_range_bit, pin_power_down_bit, pin_mode_scaled,
             pin_mode_fast, pin_output_coding_select} = w[5:0];
            repeat (6) @(negedge clk_sys);
            chk_cfg(w[5:0]);
        end
        conclude;
    end
endmodule
`default_nettype wire
